//--- src/base_window_match.v
// Address comparator for one target window of fixed size.
// Assumes the base register already holds only the upper bits.
`timescale 1ns/1ps
module base_window_match #(
   parameter LSB = 20
) (
   input wire [31:0] address,
   input wire [31-LSB:0] base,
   output wire hit
);

   // Upper address bits against programmed base
   assign hit = (address[31:LSB] == base);

endmodule

//--- src/cfg_header_regs.vh
// Constants for the configuration header register bank: offsets, fields, reset values.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef CFG_HEADER_REGS_VH
`define CFG_HEADER_REGS_VH

// ----------------------------------------
// Internal register offsets
// ----------------------------------------
`define OFS_MEM1_UPPER_BASE 16'hd01c
`define OFS_MEM2_BASE 16'hd020
`define OFS_IO_BASE 16'hd024
`define OFS_SUBSYS_IDENT 16'hd02c
`define OFS_CAP_OFFSET 16'hd034
`define OFS_LAT_GNT_INT 16'hd03c

// ----------------------------------------
// Configuration space offsets of the window bases
// ----------------------------------------
`define CFG_OFS_MEM2_BASE 8'h20
`define CFG_OFS_IO_BASE 8'h24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MEM2_BASE_LSB 20
`define IO_BASE_LSB 8
`define MAX_LAT_LSB 24
`define MIN_GNT_LSB 16
`define INT_PIN_LSB 8
`define SUBSYS_IDENT_LSB 16

// ----------------------------------------
// Fixed values and reset values
// ----------------------------------------
`define MEM2_PREFETCH 1'b0
`define MEM2_TYPE 2'b00
`define MEM2_SPACE 1'b0
`define IO_SPACE_BIT 1'b1
`define CAP_OFFSET_VALUE 8'hdc
`define MAX_LAT_RESET 8'h0a
`define MIN_GNT_RESET 8'h02
`define INT_PIN_RESET 8'h01
`define INT_LINE_RESET 8'h00
`define BASE_RESET 32'h0000_0000

`endif

//--- src/pci_target_config_header_regs.v
// Configuration header register bank: window bases, subsystem identity,
// capability offset and latency, grant and interrupt fields.
// Assumes a one-cycle register port, an initialization loader and agent-only mode flag.
// Assumes both ports share sys_clk and that load_valid only pulses during initialization.
//
// Behaviour
// RL1 - All registers here are inaccessible while the controller runs in agent-only mode.
// RL2 - Software never writes the upper base register of memory window one.
// RL3 - Memory window two base is writable in bits 31:20; bits 19:4 reserved.
// RL4 - Memory window two reads not prefetchable, 32-bit type, memory space.
// RL5 - I/O window base is writable in bits 31:8; bits 7:1 reserved.
// RL6 - I/O base bit 0 always reads one.
// RL7 - Subsystem ident and vendor ident read-only, loadable at initialization.
// RL8 - Capability offset reads constant 0xDC in bits 7:0, upper bits zero.
// RL9 - Maximum latency field bits 31:24 resets to 0x0A, loadable.
// RL10 - Minimum grant field bits 23:16 resets to 0x02, loadable.
// RL11 - Interrupt pin code bits 15:8 resets to 0x01, loadable.
// RL12 - Interrupt line bits 7:0 read/write, resets to zero, no effect inside.
// RL13 - Request-2 or programmable pin interrupt routing is set by the loader.
// RL14 - Window two base at config 0x20, I/O base at config 0x24.
// RL15 - A target access is claimed when upper address bits equal a window base.
`timescale 1ns/1ps
`include "cfg_header_regs.vh"
module pci_target_config_header_regs #(
   parameter [15:0] SUBSYS_IDENT_RESET = 16'h5a5a, // Arbitrary neutral value
   parameter [15:0] SUBSYS_VENDOR_RESET = 16'ha5a5 // Arbitrary neutral value
) (
   input wire sys_clk,
   input wire rst,
   input wire agent_only_mode,
   input wire reg_sel,
   input wire reg_wr,
   input wire [15:0] reg_addr,
   input wire [31:0] reg_wdata,
   output reg [31:0] reg_rdata,
   output reg reg_ack,
   input wire cfg_sel,
   input wire cfg_wr,
   input wire [7:0] cfg_addr,
   input wire [31:0] cfg_wdata,
   output reg [31:0] cfg_rdata,
   output reg cfg_ack,
   input wire load_valid,
   input wire [15:0] load_subsystem_ident,
   input wire [15:0] load_subsystem_vendor_ident,
   input wire [7:0] load_max_latency,
   input wire [7:0] load_min_grant,
   input wire [7:0] load_interrupt_pin,
   input wire [31:0] target_addr,
   input wire target_is_io,
   output wire target_claim
);

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   reg [11:0] mem2_base;
   reg [23:0] io_base;
   reg [15:0] subsystem_ident;
   reg [15:0] subsystem_vendor_ident;
   reg [7:0] max_latency_field;
   reg [7:0] min_grant_field;
   reg [7:0] interrupt_pin_code;
   reg [7:0] interrupt_line_field;

   // ----------------------------------------
   // Access decode
   // ----------------------------------------
   // Both ports locked out in agent-only mode; nothing taken, nothing acknowledged
   wire reg_go = reg_sel & ~agent_only_mode; // RL1
   wire cfg_go = cfg_sel & ~agent_only_mode; // RL1
   wire reg_write = reg_go & reg_wr;
   wire cfg_write = cfg_go & cfg_wr;

   // Per-port write strobes for the two window bases
   wire reg_wr_mem2 = reg_write & (reg_addr == `OFS_MEM2_BASE);
   wire cfg_wr_mem2 = cfg_write & (cfg_addr == `CFG_OFS_MEM2_BASE); // RL14
   wire reg_wr_io = reg_write & (reg_addr == `OFS_IO_BASE);
   wire cfg_wr_io = cfg_write & (cfg_addr == `CFG_OFS_IO_BASE); // RL14
   wire wr_mem2 = reg_wr_mem2 | cfg_wr_mem2;
   wire wr_io = reg_wr_io | cfg_wr_io;

   // Interrupt line is written from the internal port only
   wire wr_line = reg_write & (reg_addr == `OFS_LAT_GNT_INT); // RL12

   // Data source chosen per base, so an internal write elsewhere cannot
   // corrupt a base that the config port writes in the same cycle;
   // the internal port wins a clash on the same base
   wire [31:0] mem2_wdata = reg_wr_mem2 ? reg_wdata : cfg_wdata;
   wire [31:0] io_wdata = reg_wr_io ? reg_wdata : cfg_wdata;

   // ----------------------------------------
   // Fixed fields
   // ----------------------------------------
   // Window two is plain 32-bit memory space, never prefetchable
   wire prefetch_flag = `MEM2_PREFETCH; // RL4
   wire [1:0] memory_type = `MEM2_TYPE; // RL4
   wire memory_space_indicator = `MEM2_SPACE; // RL4
   // The I/O base always announces I/O space
   wire io_space_indicator = `IO_SPACE_BIT; // RL6
   wire [7:0] capability_list_offset = `CAP_OFFSET_VALUE; // RL8

   // Assembled register images; reserved bits read zero
   wire [31:0] mem2_image = {mem2_base, 16'h0000, prefetch_flag, memory_type, memory_space_indicator}; // RL3 RL4
   wire [31:0] io_image = {io_base, 7'h00, io_space_indicator}; // RL5 RL6
   wire [31:0] sid_image = {subsystem_ident, subsystem_vendor_ident}; // RL7
   wire [31:0] cap_image = {24'h00_0000, capability_list_offset}; // RL8
   wire [31:0] cfg2_image = {max_latency_field, min_grant_field, interrupt_pin_code, interrupt_line_field};

   // ----------------------------------------
   // Writable window bases
   // ----------------------------------------
   // Memory window two keeps only its upper twelve bits: fixed 1 MB window
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mem2_base <= 12'h000;
      end else if (wr_mem2) begin
         mem2_base <= mem2_wdata[31:`MEM2_BASE_LSB]; // RL3
      end
   end

   // I/O window keeps only its upper 24 bits: fixed 256-byte window
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         io_base <= 24'h00_0000;
      end else if (wr_io) begin
         io_base <= io_wdata[31:`IO_BASE_LSB]; // RL5
      end
   end

   // ----------------------------------------
   // Interrupt line and initialization load
   // ----------------------------------------
   // Interrupt line is plain software storage with no effect inside the bank
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         interrupt_line_field <= `INT_LINE_RESET; // RL12
      end else if (wr_line) begin
         interrupt_line_field <= reg_wdata[7:0]; // RL12
      end
   end

   // Loaded fields are read-only to both ports; only the loader changes them
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         subsystem_ident <= SUBSYS_IDENT_RESET; // RL7
         subsystem_vendor_ident <= SUBSYS_VENDOR_RESET; // RL7
         max_latency_field <= `MAX_LAT_RESET; // RL9
         min_grant_field <= `MIN_GNT_RESET; // RL10
         interrupt_pin_code <= `INT_PIN_RESET; // RL11
      end else if (load_valid) begin
         subsystem_ident <= load_subsystem_ident; // RL7
         subsystem_vendor_ident <= load_subsystem_vendor_ident; // RL7
         max_latency_field <= load_max_latency; // RL9
         min_grant_field <= load_min_grant; // RL10
         interrupt_pin_code <= load_interrupt_pin; // RL11 RL13
      end
   end

   // ----------------------------------------
   // Internal register read
   // ----------------------------------------
   reg [31:0] next_reg_rdata;
   always @* begin
      if (reg_addr == `OFS_MEM2_BASE) begin
         next_reg_rdata = mem2_image;
      end else if (reg_addr == `OFS_IO_BASE) begin
         next_reg_rdata = io_image;
      end else if (reg_addr == `OFS_SUBSYS_IDENT) begin
         next_reg_rdata = sid_image;
      end else if (reg_addr == `OFS_CAP_OFFSET) begin
         next_reg_rdata = cap_image;
      end else if (reg_addr == `OFS_LAT_GNT_INT) begin
         next_reg_rdata = cfg2_image;
      end else begin
         next_reg_rdata = 32'h0000_0000; // Unused upper base and unmapped read zero, RL2
      end
   end

   // Configuration port read
   reg [31:0] next_cfg_rdata;
   always @* begin
      if (cfg_addr == `CFG_OFS_MEM2_BASE) begin
         next_cfg_rdata = mem2_image;
      end else if (cfg_addr == `CFG_OFS_IO_BASE) begin
         next_cfg_rdata = io_image;
      end else begin
         next_cfg_rdata = 32'h0000_0000;
      end
   end

   // Registered answers, one cycle after the request
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
         reg_ack <= 1'b0;
         cfg_rdata <= 32'h0000_0000;
         cfg_ack <= 1'b0;
      end else begin
         reg_ack <= reg_go; // RL1
         cfg_ack <= cfg_go; // RL1
         reg_rdata <= (reg_go & ~reg_wr) ? next_reg_rdata : 32'h0000_0000;
         cfg_rdata <= (cfg_go & ~cfg_wr) ? next_cfg_rdata : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Target window claim
   // ----------------------------------------
   wire mem2_hit;
   wire io_hit;
   base_window_match #(.LSB(`MEM2_BASE_LSB)) u_mem2_match (
      .address(target_addr),
      .base(mem2_base),
      .hit(mem2_hit)
   );
   base_window_match #(.LSB(`IO_BASE_LSB)) u_io_match (
      .address(target_addr),
      .base(io_base),
      .hit(io_hit)
   );
   assign target_claim = target_is_io ? io_hit : mem2_hit; // RL15

endmodule

//--- test/cfg_hdr_props_properties.sv
// Port assertions for the configuration header register bank.
// Assumes binding to the bank; sees only its ports, one clock domain.
`timescale 1ns/1ps
module cfg_hdr_props (
   input wire sys_clk,
   input wire rst,
   input wire agent_only_mode,
   input wire reg_sel,
   input wire reg_wr,
   input wire [15:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire [31:0] reg_rdata,
   input wire reg_ack,
   input wire cfg_sel,
   input wire cfg_wr,
   input wire [7:0] cfg_addr,
   input wire [31:0] cfg_rdata,
   input wire cfg_ack
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Read requests that the bank takes
   wire rd = reg_sel && !reg_wr && !agent_only_mode;
   wire crd = cfg_sel && !cfg_wr && !agent_only_mode;
   property p_aom_reg; agent_only_mode && reg_sel |=> !reg_ack; endproperty
   a_aom_reg: assert property (p_aom_reg) else $error("ack in agent mode");
   property p_aom_cfg; agent_only_mode && cfg_sel |=> !cfg_ack; endproperty
   a_aom_cfg: assert property (p_aom_cfg) else $error("config ack in agent mode");
   property p_upper; rd && reg_addr == 16'hd01c |=> reg_ack && reg_rdata == 32'h0000_0000; endproperty
   a_upper: assert property (p_upper) else $error("upper base not zero");
   property p_mem; rd && reg_addr == 16'hd020 |=> reg_ack && reg_rdata[19:0] == 20'h0_0000; endproperty
   a_mem: assert property (p_mem) else $error("window two low bits");
   property p_io; rd && reg_addr == 16'hd024 |=> reg_rdata[7:0] == 8'h01; endproperty
   a_io: assert property (p_io) else $error("io base low bits");
   property p_cap; rd && reg_addr == 16'hd034 |=> reg_rdata == 32'h0000_00dc; endproperty
   a_cap: assert property (p_cap) else $error("capability offset");
   property p_cfgio; crd && cfg_addr == 8'h24 |=> cfg_ack && cfg_rdata[0]; endproperty
   a_cfgio: assert property (p_cfgio) else $error("config io bit");
   property p_wr;
      reg_sel && reg_wr && reg_addr == 16'hd020 && !agent_only_mode ##1 !reg_sel && !(cfg_sel && cfg_wr)
      ##1 rd && reg_addr == 16'hd020 |=> reg_rdata[31:20] == $past(reg_wdata[31:20], 3);
   endproperty
   a_wr: assert property (p_wr) else $error("window two base not written");
endmodule
bind pci_target_config_header_regs cfg_hdr_props u_props (.sys_clk, .rst, .agent_only_mode, .reg_sel, .reg_wr,
   .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .cfg_sel, .cfg_wr, .cfg_addr, .cfg_rdata, .cfg_ack);

//--- test/cfg_host_model.sv
// Host model issuing configuration cycles on the config port.
// Assumes the bank registers its answer on the taking edge.
`timescale 1ns/1ps
module cfg_host_model (
   input wire sys_clk,
   input wire [31:0] cfg_rdata,
   input wire cfg_ack,
   output reg cfg_sel = 1'b0,
   output reg cfg_wr = 1'b0,
   output reg [7:0] cfg_addr = 8'h00,
   output reg [31:0] cfg_wdata = 32'h0000_0000
);
   reg [31:0] q;
   reg k;
   // One access; never writes the unused upper base, lines change once released
   task acc(input w, input [7:0] a, input [31:0] d);
      @(negedge sys_clk);
      {cfg_sel, cfg_wr, cfg_addr, cfg_wdata} = {1'b1, w & (a != 8'h1c), a, d};
      @(negedge sys_clk);
      {cfg_sel, cfg_addr, cfg_wdata} = {1'b0, ~a, ~d};
      q = cfg_rdata;
      k = cfg_ack;
   endtask
endmodule

//--- test/tb_top.sv
// Self-checking bench for the configuration header register bank.
// Assumes the host model drives the config port; bench drives the rest.
`timescale 1ns/1ps
module tb_top;
   reg sys_clk = 1'b0, rst = 1'b1, agent_only_mode = 1'b0, reg_sel = 1'b0, reg_wr = 1'b0, load_valid = 1'b0;
   reg [15:0] reg_addr = 16'h0000, load_subsystem_ident = 16'h0000, load_subsystem_vendor_ident = 16'h0000;
   reg [31:0] reg_wdata = 32'h0000_0000, target_addr = 32'h0000_0000, q;
   reg [7:0] load_max_latency = 8'h00, load_min_grant = 8'h00, load_interrupt_pin = 8'h00;
   reg target_is_io = 1'b0, k;
   wire [31:0] reg_rdata, cfg_rdata, cfg_wdata;
   wire [7:0] cfg_addr;
   wire reg_ack, cfg_ack, cfg_sel, cfg_wr, target_claim;
   integer n_errors = 0, checks_done = 0;
   localparam [15:0] SID_RESET = 16'h6c3e; // Arbitrary neutral value
   localparam [15:0] SVID_RESET = 16'h3e6c; // Arbitrary neutral value
   always #5 sys_clk = ~sys_clk;
   pci_target_config_header_regs #(.SUBSYS_IDENT_RESET(SID_RESET), .SUBSYS_VENDOR_RESET(SVID_RESET)) DUT (
      .sys_clk, .rst, .agent_only_mode, .reg_sel, .reg_wr, .reg_addr, .reg_wdata,
      .reg_rdata, .reg_ack, .cfg_sel, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_rdata, .cfg_ack, .load_valid,
      .load_subsystem_ident, .load_subsystem_vendor_ident, .load_max_latency, .load_min_grant,
      .load_interrupt_pin, .target_addr, .target_is_io, .target_claim);
   cfg_host_model host (.sys_clk, .cfg_rdata, .cfg_ack, .cfg_sel, .cfg_wr, .cfg_addr, .cfg_wdata);
   // Verdict and end of run
   task close_out;
      if (n_errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Compare one value
   task chk(input string nm, input [31:0] e, input [31:0] g);
      checks_done = checks_done + 1;
      if (g !== e) begin
         n_errors = n_errors + 1;
         $display("unexpected %0s exp %h got %h", nm, e, g);
      end
   endtask
   // One internal access, address and data change once released
   task acc(input w, input [15:0] a, input [31:0] d);
      @(negedge sys_clk);
      {reg_sel, reg_wr, reg_addr, reg_wdata} = {1'b1, w & (a != 16'hd01c), a, d};
      @(negedge sys_clk);
      {reg_sel, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
      q = reg_rdata;
      k = reg_ack;
   endtask
   // Read and compare data and ack
   task rc(input [15:0] a, input [31:0] e, input ka);
      acc(1'b0, a, 32'h0000_0000);
      chk("rdata", e, q);
      chk("ack", {31'h0000_0000, ka}, {31'h0000_0000, k});
   endtask
   // Target claim for one address
   task tc(input [31:0] a, input io, input e);
      @(negedge sys_clk);
      {target_addr, target_is_io} = {a, io};
      #1 chk("claim", {31'h0000_0000, e}, {31'h0000_0000, target_claim});
   endtask
   // Watchdog
   initial begin
      #50000 n_errors = n_errors + 1;
      close_out;
   end
   // Main sequence
   initial begin
      repeat (16) @(negedge sys_clk);
      rst = 1'b0;
      rc(16'hd020, 32'h0000_0000, 1'b1);
      rc(16'hd024, 32'h0000_0001, 1'b1);
      rc(16'hd034, 32'h0000_00dc, 1'b1);
      rc(16'hd03c, 32'h0a02_0100, 1'b1);
      rc(16'hd02c, {SID_RESET, SVID_RESET}, 1'b1);
      acc(1'b1, 16'hd020, 32'hffff_ffff);
      rc(16'hd020, 32'hfff0_0000, 1'b1);
      acc(1'b1, 16'hd024, 32'hffff_ffff);
      rc(16'hd024, 32'hffff_ff01, 1'b1);
      acc(1'b1, 16'hd01c, 32'hffff_ffff);
      rc(16'hd01c, 32'h0000_0000, 1'b1);
      acc(1'b1, 16'hd02c, 32'hffff_ffff);
      acc(1'b1, 16'hd034, 32'hffff_ffff);
      rc(16'hd02c, {SID_RESET, SVID_RESET}, 1'b1);
      rc(16'hd034, 32'h0000_00dc, 1'b1);
      acc(1'b1, 16'hd03c, 32'h1234_5678);
      rc(16'hd03c, 32'h0a02_0178, 1'b1);
      @(negedge sys_clk);
      {load_valid, load_subsystem_ident, load_subsystem_vendor_ident} = {1'b1, 16'h1357, 16'h2468};
      {load_max_latency, load_min_grant, load_interrupt_pin} = {8'h33, 8'h44, 8'h04};
      @(negedge sys_clk);
      load_valid = 1'b0;
      rc(16'hd02c, 32'h1357_2468, 1'b1);
      rc(16'hd03c, 32'h3344_0478, 1'b1);
      tc(32'hfff1_2345, 1'b0, 1'b1);
      tc(32'hffe0_0000, 1'b0, 1'b0);
      tc(32'hffff_ff7f, 1'b1, 1'b1);
      tc(32'hffff_fe00, 1'b1, 1'b0);
      host.acc(1'b0, 8'h24, 32'h0000_0000);
      chk("cfg_rdata", 32'hffff_ff01, host.q);
      chk("cfg_ack", 32'h0000_0001, {31'h0000_0000, host.k});
      host.acc(1'b1, 8'h20, 32'h1230_0000);
      rc(16'hd020, 32'h1230_0000, 1'b1);
      host.acc(1'b1, 8'h24, 32'habcd_ef00);
      rc(16'hd024, 32'habcd_ef01, 1'b1);
      @(negedge sys_clk);
      agent_only_mode = 1'b1;
      rc(16'hd034, 32'h0000_0000, 1'b0);
      acc(1'b1, 16'hd03c, 32'h0000_0000);
      host.acc(1'b0, 8'h20, 32'h0000_0000);
      chk("cfg_ack", 32'h0000_0000, {31'h0000_0000, host.k});
      chk("cfg_rdata", 32'h0000_0000, host.q);
      agent_only_mode = 1'b0;
      rc(16'hd03c, 32'h3344_0478, 1'b1);
      // Mid-run reset restores bases, line, loaded fields and identity
      @(negedge sys_clk);
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      rc(16'hd020, 32'h0000_0000, 1'b1);
      rc(16'hd024, 32'h0000_0001, 1'b1);
      rc(16'hd02c, {SID_RESET, SVID_RESET}, 1'b1);
      rc(16'hd03c, 32'h0a02_0100, 1'b1);
      close_out;
   end
endmodule
